// [gsdp_channel.sv]
/*
 One channel of threshold tracking and switching.
 Assumes processed_signal is synchronous to clk_sys.
*/
`timescale 1ns/1ps
module gsdp_channel
(
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic [11:0] processed_signal,
	output logic state,
	output logic toggle,
	output logic [11:0] operate_threshold,
	output logic [11:0] release_threshold
);
	logic [11:0] pk_max;
	logic [11:0] pk_min;
	logic [11:0] next_pk_max;
	logic [11:0] next_pk_min;
	logic [11:0] next_op;
	logic [11:0] next_rp;
	logic next_state;
	logic [12:0] sum;
	logic [11:0] span;
	logic [11:0] tgt_op;
	logic [11:0] tgt_rp;

	function automatic logic [11:0] slew(input logic [11:0] cur, input logic [11:0] tgt);
		logic [11:0] r;
		r = tgt;
		if (tgt > cur && (tgt - cur) > gsdp_pkg::MAX_STEP)
			r = cur + gsdp_pkg::MAX_STEP;
		else if (cur > tgt && (cur - tgt) > gsdp_pkg::MAX_STEP)
			r = cur - gsdp_pkg::MAX_STEP;
		return r;
	endfunction

	// ----------------------------------------
	// Peak tracking and switching
	// ----------------------------------------
	always_comb
	begin
		next_pk_max = pk_max;
		next_pk_min = pk_min;
		next_op = operate_threshold;
		next_rp = release_threshold;
		next_state = state;
		toggle = 1'b0;
		sum = 13'(pk_max) + 13'(pk_min);
		span = (pk_max > pk_min) ? (pk_max - pk_min) : 12'h000;
		tgt_op = sum[12:1] + (span >> gsdp_pkg::HYS_SHIFT);
		tgt_rp = sum[12:1] - (span >> gsdp_pkg::HYS_SHIFT);
		if (state && processed_signal > pk_max)
			next_pk_max = processed_signal;
		if (!state && processed_signal < pk_min)
			next_pk_min = processed_signal;
		if (!state && processed_signal > operate_threshold)
		begin
			next_state = 1'b1;
			toggle = 1'b1;
			next_pk_max = processed_signal;
			next_op = slew(operate_threshold, tgt_op);
			next_rp = slew(release_threshold, tgt_rp);
		end
		else if (state && processed_signal < release_threshold)
		begin
			next_state = 1'b0;
			toggle = 1'b1;
			next_pk_min = processed_signal;
			next_op = slew(operate_threshold, tgt_op);
			next_rp = slew(release_threshold, tgt_rp);
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state <= 1'b0;
			pk_max <= gsdp_pkg::SIG_MID;
			pk_min <= gsdp_pkg::SIG_MID;
			operate_threshold <= gsdp_pkg::INIT_OP;
			release_threshold <= gsdp_pkg::INIT_RP;
		end
		else
		begin
			state <= next_state;
			pk_max <= next_pk_max;
			pk_min <= next_pk_min;
			operate_threshold <= next_op;
			release_threshold <= next_rp;
		end
	end
endmodule

// [gsdp_ctrl_model.sv]
/*
 Controller model: measures pulse width in clock cycles.
 Assumes pulse_out is synchronous to clk_sys.
*/
`timescale 1ns/1ps
module gsdp_ctrl_model
(
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic pulse_out,
	output int width,
	output int count
);
	// -------
	// Measure
	// -------
	int run;
	// One cycle resolution bounds the shortest gap it can tell apart
	always_ff @(posedge clk_sys or negedge arst_n)
		if (!arst_n)
		begin
			run <= 0;
			width <= 0;
			count <= 0;
		end
		else if (pulse_out)
			run <= run + 1;
		else if (run != 0)
		begin
			width <= run;
			count <= count + 1;
			run <= 0;
		end
endmodule

// [gsdp_monitor.sv]
/*
 Checker on the pulser top ports.
 Assumes it is bound to gsdp_top.
*/
`timescale 1ns/1ps
module gsdp_monitor
(
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic [11:0] processed_signal_a,
	input wire logic pulse_out,
	input wire logic calibrated,
	input wire logic [1:0] last_dir
);
	// ------
	// Checks
	// ------
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!arst_n);
	int hi, age;
	logic [11:0] prev;
	// Saturating, so long merged pulses never wrap
	always_ff @(posedge clk_sys or negedge arst_n)
		if (!arst_n)
		begin
			hi <= 0;
			age <= 99;
			prev <= 12'h800;
		end
		else
		begin
			hi <= pulse_out ? hi + (hi < 99999) : 0;
			age <= processed_signal_a != prev ? 0 : age + (age < 99);
			prev <= processed_signal_a;
		end
	sequence s_rise;
		$rose(pulse_out);
	endsequence
	fwd_width_a: assert property ($fell(pulse_out) && last_dir == 2'h0 |-> hi >= gsdp_pkg::FWD_CYC)
		else $error("forward pulse short");
	rev_width_a: assert property ($fell(pulse_out) && last_dir == 2'h1 |-> hi >= gsdp_pkg::REV_CYC)
		else $error("reverse pulse short");
	nd_width_a: assert property ($fell(pulse_out) && last_dir == 2'h2 |-> hi >= gsdp_pkg::ND_CYC)
		else $error("nondirection pulse short");
	pulse_hold_a: assert property (s_rise |-> pulse_out [*8])
		else $error("pulse dropped early");
	trig_chan_a: assert property (s_rise |-> age <= 6)
		else $error("pulse without channel one move");
	dir_cal_a: assert property (s_rise |-> (last_dir == 2'h2) or (##[0:2] calibrated))
		else $error("direction before calibration");
	cal_keep_a: assert property (calibrated |=> calibrated)
		else $error("calibration lost");
	dir_pulse_a: assert property ($changed(last_dir) |-> pulse_out)
		else $error("direction change without pulse");
endmodule

bind gsdp_top gsdp_monitor u_mon (.clk_sys(clk_sys), .arst_n(arst_n),
	.processed_signal_a(processed_signal_a), .pulse_out(pulse_out),
	.calibrated(calibrated), .last_dir(last_dir));

// [gsdp_pkg.sv]
/*
 Shared constants of the gear speed and direction pulser: sample width,
 threshold rules, pulse widths and calibration counts.
 Assumes a 250 MHz system clock.
*/
package gsdp_pkg;
	// ----------------------------------------
	// Signal path
	// ----------------------------------------
	localparam int SIG_W = 12;
	localparam logic [11:0] SIG_MID = 12'h800;
	localparam logic [11:0] MAX_STEP = 12'h040;
	localparam int HYS_SHIFT = 2;
	localparam logic [11:0] INIT_OP = 12'h880;
	localparam logic [11:0] INIT_RP = 12'h780;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_MHZ = 250;
	localparam int FWD_US = 45;
	localparam int REV_US = 90;
	localparam int ND_US = 180;
	localparam int FWD_CYC = FWD_US * CLK_MHZ;
	localparam int REV_CYC = REV_US * CLK_MHZ;
	localparam int ND_CYC = ND_US * CLK_MHZ;
	localparam int CNT_W = 16;
	localparam logic [2:0] CAL_EDGES = 3'h4;
	localparam logic [2:0] DIR_OK_EDGES = 3'h2;
	typedef enum logic [1:0] {GSDP_FWD, GSDP_REV, GSDP_ND} gsdp_dir_t;
endpackage

// [gsdp_pulse.sv]
/*
 Pulse timer: each trigger starts or restarts the pulse, width chosen by direction code.
 Assumes triggers come from clk_sys logic.
*/
`timescale 1ns/1ps
module gsdp_pulse
(
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic trigger,
	input wire logic [1:0] dir,
	output logic pulse_out
);
	logic [15:0] cnt;
	logic [15:0] next_cnt;
	logic next_out;

	// ----------------------------------------
	// Width counter
	// ----------------------------------------
	always_comb
	begin
		next_cnt = cnt;
		next_out = pulse_out;
		if (trigger)
		begin
			next_out = 1'b1;
			case (dir)
				gsdp_pkg::GSDP_FWD: next_cnt = 16'(gsdp_pkg::FWD_CYC - 1);
				gsdp_pkg::GSDP_REV: next_cnt = 16'(gsdp_pkg::REV_CYC - 1);
				default: next_cnt = 16'(gsdp_pkg::ND_CYC - 1);
			endcase
		end
		else if (cnt != 16'h0000)
			next_cnt = cnt - 16'h0001;
		else
			next_out = 1'b0;
	end

	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cnt <= 16'h0000;
			pulse_out <= 1'b0;
		end
		else
		begin
			cnt <= next_cnt;
			pulse_out <= next_out;
		end
	end
endmodule

// [gsdp_top.sv]
/*
 Gear speed and direction pulser: two threshold channels, direction
 decision on channel one switching, pulse width encoding.
 Assumes processed samples arrive as asynchronous pin inputs and are
 stable across the two synchroniser stages (slow analog-derived words).
*/
`timescale 1ns/1ps
module gsdp_top
(
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic [11:0] processed_signal_a,
	input wire logic [11:0] processed_signal_b,
	output logic pulse_out,
	output logic calibrated,
	output logic [1:0] last_dir
);
	logic [11:0] sig_in [2];
	logic [1:0] st;
	logic [1:0] tog;
	logic st_a;
	logic st_b;
	logic tog_a;
	logic tog_b;
	logic [2:0] edge_cnt;
	logic [2:0] next_edge_cnt;
	logic [2:0] b_run;
	logic [2:0] next_b_run;
	logic b_since;
	logic next_b_since;
	logic next_calibrated;
	logic [1:0] next_last_dir;
	logic [1:0] dir_sel;

	assign sig_in[0] = processed_signal_a;
	assign sig_in[1] = processed_signal_b;
	assign st_a = st[0];
	assign st_b = st[1];
	assign tog_a = tog[0];
	assign tog_b = tog[1];

	// ----------------------------------------
	// Channels with input synchronisers
	// ----------------------------------------
	// Separate instances keep each threshold pair independent
	for (genvar ch = 0; ch < 2; ch++)
	begin : g_ch
		logic [11:0] meta;
		logic [11:0] sync;

		always_ff @(posedge clk_sys or negedge arst_n)
		begin
			if (!arst_n)
			begin
				meta <= gsdp_pkg::SIG_MID;
				sync <= gsdp_pkg::SIG_MID;
			end
			else
			begin
				meta <= sig_in[ch];
				sync <= meta;
			end
		end

		gsdp_channel u_ch
		(
			.clk_sys(clk_sys),
			.arst_n(arst_n),
			.processed_signal(sync),
			.state(st[ch]),
			.toggle(tog[ch]),
			.operate_threshold(),
			.release_threshold()
		);
	end

	// ----------------------------------------
	// Direction decision
	// ----------------------------------------
	// Phase of channel two at channel one switching gives direction.
	// Channel two must have switched since the previous channel one edge,
	// and repeatedly, else vibration is assumed and width is non-direction.
	always_comb
	begin
		next_edge_cnt = edge_cnt;
		next_calibrated = calibrated;
		next_b_since = b_since | tog_b;
		next_b_run = b_run;
		next_last_dir = last_dir;
		dir_sel = 2'(gsdp_pkg::GSDP_ND);
		if (tog_a)
		begin
			if (edge_cnt != gsdp_pkg::CAL_EDGES)
				next_edge_cnt = edge_cnt + 3'h1;
			else
				next_calibrated = 1'b1;
			if (b_since || tog_b)
			begin
				if (b_run != 3'h7)
					next_b_run = b_run + 3'h1;
			end
			else
				next_b_run = 3'h0;
			next_b_since = 1'b0;
			if (calibrated && b_run >= gsdp_pkg::DIR_OK_EDGES && (b_since || tog_b))
			begin
				if (st_a == st_b)
					dir_sel = 2'(gsdp_pkg::GSDP_FWD);
				else
					dir_sel = 2'(gsdp_pkg::GSDP_REV);
			end
			next_last_dir = dir_sel;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			edge_cnt <= 3'h0;
			calibrated <= 1'b0;
			b_since <= 1'b0;
			b_run <= 3'h0;
			last_dir <= 2'(gsdp_pkg::GSDP_ND);
		end
		else
		begin
			edge_cnt <= next_edge_cnt;
			calibrated <= next_calibrated;
			b_since <= next_b_since;
			b_run <= next_b_run;
			last_dir <= next_last_dir;
		end
	end

	// ----------------------------------------
	// Output pulse
	// ----------------------------------------
	// Pulse starts only on channel one switching; output idles low before it.
	// A new edge during a pulse restarts it: the controller must space edges.
	gsdp_pulse u_pulse
	(
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.trigger(tog_a),
		.dir(dir_sel),
		.pulse_out(pulse_out)
	);
endmodule

// [tb_top.sv]
/*
 Bench: drives both channel words, checks direction, calibration, widths.
 Assumes gsdp_top and the controller model.
*/
`timescale 1ns/1ps
module tb_top;
	// -----
	// Bench
	// -----
	logic clk_sys = 1'b0;
	logic arst_n = 1'b0;
	logic [11:0] sig_a = 12'h800, sig_b = 12'h800;
	logic pulse_out, calibrated;
	logic [1:0] last_dir;
	logic [1:0] exp_dir = 2'h2;
	int width, count, cyc, na, run, exp_cnt;
	int bad_count = 0, num_checks = 0;
	bit moved, st_b;
	gsdp_top u_dut (.clk_sys(clk_sys), .arst_n(arst_n), .processed_signal_a(sig_a),
		.processed_signal_b(sig_b), .pulse_out(pulse_out), .calibrated(calibrated),
		.last_dir(last_dir));
	gsdp_ctrl_model u_ctrl (.clk_sys(clk_sys), .arst_n(arst_n), .pulse_out(pulse_out),
		.width(width), .count(count));
	initial
		forever #2 clk_sys = ~clk_sys;
	task automatic check(input string what, input logic [31:0] seen, exp);
		num_checks++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("Error %s expected %0d seen %0d", what, exp, seen);
		end
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Levels sit far past any threshold, so every move is a real switch
	task automatic move(input bit ch_b, input bit up);
		@(posedge clk_sys);
		if (ch_b)
		begin
			sig_b <= (up ? 12'hB00 : 12'h400) + 12'($urandom % 256);
			moved = 1;
			st_b = up;
		end
		else
		begin
			sig_a <= (up ? 12'hB00 : 12'h400) + 12'($urandom % 256);
			na++;
			run = moved ? run + 1 : 0;
			moved = 0;
			// Direction needs calibration done before this edge and three linked edges
			exp_dir = (na < 6 || run < 3) ? 2'h2 : (up != st_b ? 2'h0 : 2'h1);
		end
		repeat (8) @(posedge clk_sys);
		check("last_dir", last_dir, exp_dir);
		check("calibrated", calibrated, na >= 5);
	endtask
	task automatic wait_end(input int lo, hi);
		int n;
		n = 0;
		exp_cnt++;
		while (count != exp_cnt && n < 50000)
		begin
			@(posedge clk_sys);
			n++;
		end
		check("count", count, exp_cnt);
		check("width", width >= lo && width <= hi ? lo : width, lo);
	endtask
	always @(posedge clk_sys)
	begin
		cyc++;
		if (cyc == 95000)
		begin
			bad_count++;
			print_verdict();
		end
	end
	initial
	begin
		void'($urandom(32'hA2D38312));
		repeat (16) @(posedge clk_sys);
		arst_n <= 1'b1;
		repeat (10)
		begin
			@(posedge clk_sys);
			sig_a <= 12'h790 + 12'($urandom % 224);
			repeat (5) @(posedge clk_sys);
			check("idle", pulse_out, 0);
		end
		move(1, 1);
		move(1, 0);
		check("b only", pulse_out, 0);
		for (int i = 0; i < 11; i++)
			move(i[0], !i[1]);
		wait_end(gsdp_pkg::FWD_CYC, gsdp_pkg::FWD_CYC + 200);
		move(0, 1);
		wait_end(gsdp_pkg::ND_CYC, gsdp_pkg::ND_CYC);
		for (int i = 0; i < 6; i++)
			move(!i[0], i[1]);
		wait_end(gsdp_pkg::REV_CYC, gsdp_pkg::REV_CYC + 200);
		print_verdict();
	end
endmodule
